// *** rtl/mcs_regs.sv ***
// Purpose: Configuration, limit status and alert mask registers of a
//          current/power monitor, reached byte-wise from the serial engine.
// Assumes: Byte strobes and measurement events arrive on mclk; only the
//          convert pin is asynchronous.
// Notes:   Alert and pin outputs are registered, one cycle behind flags.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Registers are 16 bits, carried as two bytes, high byte first.
// - Config bit 15 written as one resets every register; bit reads zero.
// - Config bit 13 picks bus range: 0 is 16V, 1 is 32V; default 1.
// - Config bits 12:11 pick shunt gain 1, /2, /4, /8; default /8.
// - Config bits 10:7 set bus converter resolution or averaging.
// - Config bits 6:3 set shunt converter resolution or averaging.
// - Top bit 0: resolution 9-12 bits; top bit 1: 1 to 128 samples.
// - Config bits 2:0 pick operating mode; default both continuous.
// - Flags set on violation, hold when latched, clear on read unless active.
// - Status 15 bus over high warning; 14 bus under low warning.
// - Status 13 sets when power exceeds its warning limit.
// - Status 12 and 11 are positive and negative shunt warnings.
// - Status 10, 9, 8 are bus high, bus low and power over-limits.
// - Status 7 and 6 are positive and negative severe shunt limits.
// - Status 5 sets once a whole measurement cycle has finished.
// - Done clears on active-mode config write, status read or convert.
// - Alert flag clears only on status read, alert disable or soft reset.
// - Status 3 flags math overflow and drives no pin output.
// - Mask bits 15:5 gate status 15:5 onto alert, not the flags.
// - Mask bit 3 enables the alert output; default off.
// - Mask bits 2:0 enable severe, over-limit and warning pins.
module mcs_regs #(
  parameter int NFLAG = mcs_pkg::LIMIT_FLAGS
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   acc_start,
  input  wire logic [7:0]             acc_ptr,
  input  wire logic                   wr_strobe,
  input  wire logic [7:0]             wr_byte,
  input  wire logic                   rd_req,
  output logic      [7:0]             rd_byte,
  output logic                        rd_valid,
  input  wire logic [NFLAG-1:0]       limit_exceeded,
  input  wire logic                   warn_latch_en,
  input  wire logic                   limit_latch_en,
  input  wire logic                   severe_latch_en,
  input  wire logic                   conv_done_pulse,
  input  wire logic                   math_overflow_pulse,
  input  wire logic                   convert_pin,
  output logic                        bus_range_select,
  output logic      [1:0]             shunt_gain_select,
  output logic      [3:0]             bus_conv_setting,
  output logic      [3:0]             shunt_conv_setting,
  output logic      [3:0]             bus_res_bits,
  output logic      [2:0]             bus_avg_log2,
  output logic      [3:0]             shunt_res_bits,
  output logic      [2:0]             shunt_avg_log2,
  output logic                        shunt_meas_en,
  output logic                        bus_meas_en,
  output logic                        continuous_mode,
  output logic                        convert_trigger,
  output logic                        alert_n_out,
  output logic                        alert_n_oe,
  output logic                        warning_pin,
  output logic                        limit_pin,
  output logic                        severe_pin
);

  // ==========================================================================
  // Parameter check
  initial begin
    if (NFLAG != mcs_pkg::LIMIT_FLAGS) begin
      $error("NFLAG must equal the number of limit flags");
    end
  end

  // ==========================================================================
  // Registers and byte assembly
  logic [15:0]      device_config;
  logic [15:0]      alert_mask_enable;
  logic [NFLAG-1:0] limit_flag;
  logic             conversion_done_flag;
  logic             alert_active_flag;
  logic             math_overflow_flag;
  logic [7:0]       wr_high;
  logic             wr_phase;
  logic             rd_phase;
  logic [15:0]      rd_shadow;
  logic [15:0]      wr_word;
  logic [15:0]      limit_status;
  logic [15:0]      read_word;
  logic             wr_commit;
  logic             soft_rst;
  logic             status_read;
  logic             cfg_write_clear;
  logic             alert_cause;
  assign wr_word   = {wr_high, wr_byte};
  assign wr_commit = wr_strobe && wr_phase && !acc_start;
  assign soft_rst  = wr_commit && acc_ptr == mcs_pkg::PTR_CONFIG
                     && wr_word[mcs_pkg::CFG_RESET_BIT];
  // The status word is consumed when its high byte is snapshotted, so an
  // event in the same cycle lands in the live flags and is read next time.
  assign status_read = rd_req && !rd_phase
                       && acc_ptr == mcs_pkg::PTR_STATUS;
  assign cfg_write_clear = wr_commit && !soft_rst
    && acc_ptr == mcs_pkg::PTR_CONFIG
    && wr_word[mcs_pkg::CFG_MODE_HI:mcs_pkg::CFG_MODE_LO]
       != mcs_pkg::MODE_POWER_DOWN
    && wr_word[mcs_pkg::CFG_MODE_HI:mcs_pkg::CFG_MODE_LO]
       != mcs_pkg::MODE_CONV_OFF;
  always_comb begin
    limit_status = mcs_pkg::STATUS_RESET;
    limit_status[mcs_pkg::ST_HIGH_BIT:mcs_pkg::LIMIT_LO] = limit_flag;
    limit_status[mcs_pkg::ST_DONE_BIT]  = conversion_done_flag;
    limit_status[mcs_pkg::ST_ALERT_BIT] = alert_active_flag;
    limit_status[mcs_pkg::ST_OVF_BIT]   = math_overflow_flag;
  end
  always_comb begin
    if (acc_ptr == mcs_pkg::PTR_CONFIG) begin
      read_word = device_config;
    end else if (acc_ptr == mcs_pkg::PTR_STATUS) begin
      read_word = limit_status;
    end else if (acc_ptr == mcs_pkg::PTR_ALERT_MASK) begin
      read_word = alert_mask_enable;
    end else begin
      read_word = mcs_pkg::UNMAPPED_READ;
    end
  end

  // Write byte pairing: the high byte waits, the low byte commits.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_phase <= 1'b0;
      wr_high  <= 8'h00;
    end else if (acc_start) begin
      wr_phase <= 1'b0;
    end else if (wr_strobe) begin
      wr_phase <= ~wr_phase;
      if (!wr_phase) begin
        wr_high <= wr_byte;
      end
    end
  end

  // Read byte pairing: the whole word is frozen when its high byte goes out.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_phase  <= 1'b0;
      rd_shadow <= 16'h0000;
      rd_byte   <= 8'h00;
      rd_valid  <= 1'b0;
    end else begin
      rd_valid <= rd_req && !acc_start;
      if (acc_start) begin
        rd_phase <= 1'b0;
      end else if (rd_req) begin
        rd_phase <= ~rd_phase;
        if (!rd_phase) begin
          rd_shadow <= read_word;
          rd_byte   <= read_word[15:8];
        end else begin
          rd_byte   <= rd_shadow[7:0];
        end
      end
    end
  end

  // ==========================================================================
  // Configuration and alert mask registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      device_config <= mcs_pkg::CONFIG_RESET;
    end else if (soft_rst) begin
      device_config <= mcs_pkg::CONFIG_RESET;
    end else if (wr_commit && acc_ptr == mcs_pkg::PTR_CONFIG) begin
      device_config <= wr_word & mcs_pkg::CONFIG_STORE;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      alert_mask_enable <= mcs_pkg::MASK_RESET;
    end else if (soft_rst) begin
      alert_mask_enable <= mcs_pkg::MASK_RESET;
    end else if (wr_commit && acc_ptr == mcs_pkg::PTR_ALERT_MASK) begin
      alert_mask_enable <= wr_word;
    end
  end

  // Field outputs follow the stored configuration one cycle later.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_range_select   <= mcs_pkg::CONFIG_RESET[mcs_pkg::CFG_RANGE_BIT];
      shunt_gain_select  <= mcs_pkg::CONFIG_RESET[
                              mcs_pkg::CFG_GAIN_HI:mcs_pkg::CFG_GAIN_LO];
      bus_conv_setting   <= mcs_pkg::CONFIG_RESET[
                              mcs_pkg::CFG_BUS_HI:mcs_pkg::CFG_BUS_LO];
      shunt_conv_setting <= mcs_pkg::CONFIG_RESET[
                              mcs_pkg::CFG_SHUNT_HI:mcs_pkg::CFG_SHUNT_LO];
      shunt_meas_en      <= mcs_pkg::CONFIG_RESET[mcs_pkg::MODE_SHUNT_BIT];
      bus_meas_en        <= mcs_pkg::CONFIG_RESET[mcs_pkg::MODE_BUS_BIT];
      continuous_mode    <= mcs_pkg::CONFIG_RESET[mcs_pkg::MODE_CONT_BIT];
    end else begin
      bus_range_select   <= device_config[mcs_pkg::CFG_RANGE_BIT];
      shunt_gain_select  <= device_config[
                              mcs_pkg::CFG_GAIN_HI:mcs_pkg::CFG_GAIN_LO];
      bus_conv_setting   <= device_config[
                              mcs_pkg::CFG_BUS_HI:mcs_pkg::CFG_BUS_LO];
      shunt_conv_setting <= device_config[
                              mcs_pkg::CFG_SHUNT_HI:mcs_pkg::CFG_SHUNT_LO];
      shunt_meas_en      <= device_config[mcs_pkg::MODE_SHUNT_BIT];
      bus_meas_en        <= device_config[mcs_pkg::MODE_BUS_BIT];
      continuous_mode    <= device_config[mcs_pkg::MODE_CONT_BIT];
    end
  end

  // ==========================================================================
  // Converter field decode, one lane for bus and one for shunt
  function automatic logic [3:0] res_of(input logic [3:0] code);
    if (code[3]) begin
      res_of = mcs_pkg::RES_MAX_BITS;
    end else begin
      res_of = mcs_pkg::RES_BASE_BITS + {2'b00, code[1:0]};
    end
  endfunction : res_of
  function automatic logic [2:0] avg_of(input logic [3:0] code);
    avg_of = code[3] ? code[2:0] : 3'h0;
  endfunction : avg_of
  logic [3:0] conv_code [2];
  logic [3:0] res_q     [2];
  logic [2:0] avg_q     [2];
  assign conv_code[0] = device_config[mcs_pkg::CFG_BUS_HI:mcs_pkg::CFG_BUS_LO];
  assign conv_code[1] = device_config[
                          mcs_pkg::CFG_SHUNT_HI:mcs_pkg::CFG_SHUNT_LO];
  for (genvar g = 0; g < 2; g++) begin : g_conv
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        res_q[g] <= mcs_pkg::RES_MAX_BITS;
        avg_q[g] <= 3'h0;
      end else begin
        res_q[g] <= res_of(conv_code[g]);
        avg_q[g] <= avg_of(conv_code[g]);
      end
    end
  end
  assign bus_res_bits   = res_q[0];
  assign bus_avg_log2   = avg_q[0];
  assign shunt_res_bits = res_q[1];
  assign shunt_avg_log2 = avg_q[1];

  // ==========================================================================
  // Convert pin: three stages, a new level is accepted when stages two and
  // three agree, which also rejects a one-sample glitch.
  logic cvt_s1;
  logic cvt_s2;
  logic cvt_s3;
  logic cvt_level;
  logic cvt_edge;
  assign cvt_edge = (cvt_s2 == cvt_s3) && cvt_s3 && !cvt_level;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cvt_s1          <= 1'b0;
      cvt_s2          <= 1'b0;
      cvt_s3          <= 1'b0;
      cvt_level       <= 1'b0;
      convert_trigger <= 1'b0;
    end else begin
      cvt_s1          <= convert_pin;
      cvt_s2          <= cvt_s1;
      cvt_s3          <= cvt_s2;
      if (cvt_s2 == cvt_s3) begin
        cvt_level <= cvt_s3;
      end
      convert_trigger <= cvt_edge;
    end
  end

  // ==========================================================================
  // Status flags: a set in the same cycle as a clear wins, except against a soft reset.
  logic [NFLAG-1:0] flag_latch;
  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    if (i >= mcs_pkg::WARN_IDX_LO) begin : g_warn
      assign flag_latch[i] = warn_latch_en;
    end else if (i >= mcs_pkg::LIM_IDX_LO) begin : g_lim
      assign flag_latch[i] = limit_latch_en;
    end else begin : g_sev
      assign flag_latch[i] = severe_latch_en;
    end
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        limit_flag[i] <= 1'b0;
      end else if (soft_rst) begin
        limit_flag[i] <= 1'b0;
      end else if (limit_exceeded[i]) begin
        limit_flag[i] <= 1'b1;
      end else if (!flag_latch[i] || status_read) begin
        limit_flag[i] <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conversion_done_flag <= 1'b0;
    end else if (soft_rst) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_done_pulse) begin
      conversion_done_flag <= 1'b1;
    end else if (cfg_write_clear || status_read || cvt_edge) begin
      conversion_done_flag <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      math_overflow_flag <= 1'b0;
    end else if (soft_rst) begin
      math_overflow_flag <= 1'b0;
    end else if (math_overflow_pulse) begin
      math_overflow_flag <= 1'b1;
    end else if (status_read) begin
      math_overflow_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Alert: only status bits 15:5 can raise it, each through its mask bit.
  assign alert_cause = alert_mask_enable[mcs_pkg::MASK_ALERT_EN]
    && |(limit_status[mcs_pkg::ST_HIGH_BIT:mcs_pkg::MASK_LO]
         & alert_mask_enable[mcs_pkg::ST_HIGH_BIT:mcs_pkg::MASK_LO]);
  // A status read clears the very flags behind the cause, so the read wins;
  // a limit still exceeded sets its flag again and re-raises the alert.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      alert_active_flag <= 1'b0;
    end else if (soft_rst) begin
      alert_active_flag <= 1'b0;
    end else if (alert_cause && !status_read) begin
      alert_active_flag <= 1'b1;
    end else if (status_read
                 || !alert_mask_enable[mcs_pkg::MASK_ALERT_EN]) begin
      alert_active_flag <= 1'b0;
    end
  end

  // The alert line is open drain: it only ever pulls low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      alert_n_out <= 1'b0;
      alert_n_oe  <= 1'b0;
      warning_pin <= 1'b0;
      limit_pin   <= 1'b0;
      severe_pin  <= 1'b0;
    end else begin
      alert_n_out <= 1'b0;
      alert_n_oe  <= alert_active_flag;
      warning_pin <= alert_mask_enable[mcs_pkg::MASK_WARN_EN]
        && |limit_flag[mcs_pkg::WARN_IDX_HI:mcs_pkg::WARN_IDX_LO];
      limit_pin   <= alert_mask_enable[mcs_pkg::MASK_LIMIT_EN]
        && |limit_flag[mcs_pkg::LIM_IDX_HI:mcs_pkg::LIM_IDX_LO];
      severe_pin  <= alert_mask_enable[mcs_pkg::MASK_SEVERE_EN]
        && |limit_flag[mcs_pkg::SEV_IDX_HI:mcs_pkg::SEV_IDX_LO];
    end
  end

endmodule : mcs_regs
`default_nettype wire

// *** rtl/mcs_pkg.sv ***
// Purpose: Shared constants for the monitor control/status register bank.
// Assumes: 16-bit registers moved as two bytes, most significant first.
// Notes:   Offsets are register pointer values, not byte addresses.
package mcs_pkg;
  // ==========================================================================
  // Register pointers
  localparam logic [7:0]  PTR_CONFIG     = 8'h00;
  localparam logic [7:0]  PTR_STATUS     = 8'h01;
  localparam logic [7:0]  PTR_ALERT_MASK = 8'h17;
  // ==========================================================================
  // Reset values
  localparam logic [15:0] CONFIG_RESET   = 16'h399F;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ  = 16'h0000;
  // Bits 15 and 14 of the configuration word are never stored.
  localparam logic [15:0] CONFIG_STORE   = 16'h3FFF;
  // ==========================================================================
  // Configuration fields
  localparam int CFG_RESET_BIT  = 15;
  localparam int CFG_RANGE_BIT  = 13;
  localparam int CFG_GAIN_HI    = 12;
  localparam int CFG_GAIN_LO    = 11;
  localparam int CFG_BUS_HI     = 10;
  localparam int CFG_BUS_LO     = 7;
  localparam int CFG_SHUNT_HI   = 6;
  localparam int CFG_SHUNT_LO   = 3;
  localparam int CFG_MODE_HI    = 2;
  localparam int CFG_MODE_LO    = 0;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] MODE_CONV_OFF   = 3'h4;
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT   = 1;
  localparam int MODE_CONT_BIT  = 2;
  // ==========================================================================
  // Status and mask fields
  localparam int LIMIT_FLAGS    = 10;
  localparam int LIMIT_LO       = 6;
  localparam int ST_HIGH_BIT    = 15;
  localparam int ST_DONE_BIT    = 5;
  localparam int ST_ALERT_BIT   = 4;
  localparam int ST_OVF_BIT     = 3;
  localparam int MASK_LO        = 5;
  localparam int MASK_ALERT_EN  = 3;
  localparam int MASK_SEVERE_EN = 2;
  localparam int MASK_LIMIT_EN  = 1;
  localparam int MASK_WARN_EN   = 0;
  // Limit flag vector index groups (index = status bit - LIMIT_LO).
  localparam int WARN_IDX_LO    = 5;
  localparam int WARN_IDX_HI    = 9;
  localparam int LIM_IDX_LO     = 2;
  localparam int LIM_IDX_HI     = 4;
  localparam int SEV_IDX_LO     = 0;
  localparam int SEV_IDX_HI     = 1;
  // ==========================================================================
  // Converter field decode
  localparam logic [3:0] RES_BASE_BITS = 4'h9;
  localparam logic [3:0] RES_MAX_BITS  = 4'hC;
endpackage : mcs_pkg

// *** test/mcs_regs_asserts.sv ***
// Purpose: Port-level checks for the monitor register bank.
// Assumes: One clock domain, mclk, with resetn as its reset.
// Notes:   Bound to every instance of the register bank.
`timescale 1ns/100ps
`default_nettype none
module mcs_regs_asserts (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       acc_start,
  input wire logic       wr_strobe,
  input wire logic       rd_req,
  input wire logic [7:0] rd_byte,
  input wire logic       rd_valid,
  input wire logic       convert_pin,
  input wire logic       convert_trigger,
  input wire logic       alert_n_out,
  input wire logic [3:0] bus_conv_setting,
  input wire logic [3:0] bus_res_bits,
  input wire logic [2:0] bus_avg_log2,
  input wire logic [3:0] shunt_conv_setting,
  input wire logic [3:0] shunt_res_bits,
  input wire logic [2:0] shunt_avg_log2
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ========================================
  // Byte access
  a_rd_answer: assert property (rd_req && !acc_start |=> rd_valid)
    else $error("read byte request not answered");
  a_rd_quiet: assert property (!rd_req |=> !rd_valid)
    else $error("read byte valid without a request");
  a_rd_hold: assert property (!rd_req && !wr_strobe |=>
    $stable(rd_byte))
    else $error("read byte changed without a request");
  // ========================================
  // Pins
  // The alert line is open drain, so only its enable may ever move.
  a_alert_low: assert property (alert_n_out == 1'b0)
    else $error("alert line driven high");
  a_trig_pulse: assert property (convert_trigger |=>
    !convert_trigger)
    else $error("convert trigger longer than one cycle");
  a_trig_cause: assert property (convert_trigger |->
    $past(convert_pin, 2) || $past(convert_pin, 3) || $past(convert_pin, 4))
    else $error("convert trigger without a pin pulse");
  // ========================================
  // Converter decode
  a_bus_res: assert property (!bus_conv_setting[3] |->
    bus_res_bits == 4'h9 + {2'h0, bus_conv_setting[1:0]} &&
    bus_avg_log2 == 3'h0)
    else $error("bus resolution decode wrong");
  a_bus_avg: assert property (bus_conv_setting[3] |->
    bus_res_bits == 4'hC && bus_avg_log2 == bus_conv_setting[2:0])
    else $error("bus averaging decode wrong");
  a_shunt_res: assert property (!shunt_conv_setting[3] |->
    shunt_res_bits == 4'h9 + {2'h0, shunt_conv_setting[1:0]} &&
    shunt_avg_log2 == 3'h0)
    else $error("shunt resolution decode wrong");
  a_shunt_avg: assert property (shunt_conv_setting[3] |->
    shunt_res_bits == 4'hC && shunt_avg_log2 == shunt_conv_setting[2:0])
    else $error("shunt averaging decode wrong");
endmodule : mcs_regs_asserts
bind mcs_regs mcs_regs_asserts u_chk (
  .mclk(mclk), .resetn(resetn), .acc_start(acc_start),
  .wr_strobe(wr_strobe), .rd_req(rd_req), .rd_byte(rd_byte),
  .rd_valid(rd_valid), .convert_pin(convert_pin),
  .convert_trigger(convert_trigger), .alert_n_out(alert_n_out),
  .bus_conv_setting(bus_conv_setting), .bus_res_bits(bus_res_bits),
  .bus_avg_log2(bus_avg_log2), .shunt_conv_setting(shunt_conv_setting),
  .shunt_res_bits(shunt_res_bits), .shunt_avg_log2(shunt_avg_log2));
`default_nettype wire

// *** test/mcs_host.sv ***
// Purpose: Host side of the serial engine: byte transfers and convert pin.
// Assumes: Drives on falling edges of mclk.
// Notes:   Released lines show inverted data so stale values never match.
`timescale 1ns/100ps
`default_nettype none
module mcs_host (
  input  wire logic       mclk,
  input  wire logic [7:0] rd_byte,
  output logic            acc_start,
  output logic [7:0]      acc_ptr,
  output logic            wr_strobe,
  output logic [7:0]      wr_byte,
  output logic            rd_req,
  output logic            convert_pin
);
  initial begin
    {acc_start, wr_strobe, rd_req, convert_pin} = 4'h0;
    acc_ptr = 8'hFF;
    wr_byte = 8'hA5;
  end
  // ========================================
  // Transfers, high byte first
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(negedge mclk) {acc_start, acc_ptr} = {1'b1, p};
    @(negedge mclk) {acc_start, wr_strobe, wr_byte} = {2'h1, d[15:8]};
    @(negedge mclk) wr_byte = d[7:0];
    @(negedge mclk) {wr_strobe, wr_byte, acc_ptr} = {1'b0, ~d[7:0], ~p};
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    @(negedge mclk) {acc_start, acc_ptr} = {1'b1, p};
    @(negedge mclk) {acc_start, rd_req} = 2'h1;
    @(negedge mclk) d[15:8] = rd_byte;
    @(negedge mclk) {rd_req, d[7:0]} = {1'b0, rd_byte};
    acc_ptr = ~p;
  endtask : rd
  // One half period of the 320 ns link rate keeps the pin up 4 mclk.
  task automatic cv();
    @(negedge mclk) convert_pin = 1'b1;
    #160 convert_pin = 1'b0;
  endtask : cv
endmodule : mcs_host
`default_nettype wire

// *** test/mcs_regs_tb.sv ***
// Purpose: Self-checking bench for the monitor register bank.
// Assumes: Inputs change on falling edges only.
// Notes:   Expected words are worked out from the bit map by hand.
`timescale 1ns/100ps
`default_nettype none
module mcs_regs_tb;
  localparam logic [7:0] CF = mcs_pkg::PTR_CONFIG;
  localparam logic [7:0] ST = mcs_pkg::PTR_STATUS;
  localparam logic [7:0] MK = mcs_pkg::PTR_ALERT_MASK;
  logic        mclk;
  logic        resetn;
  logic [9:0]  lim;
  logic        wl;
  logic        ll;
  logic        sl;
  logic        cdp;
  logic        ovp;
  logic        tseen;
  int          n_fail;
  int          num_checks;
  int          cyc;
  wire         a_st, w_st, r_rq, cvp, brs, trig, oe, wpin, lpin, spin;
  wire [7:0]   ptr, wb, rb;
  wire [1:0]   gain;
  wire [2:0]   mode;
  wire [3:0]   bcv, scv, bres, sres;
  mcs_host h (.mclk(mclk), .rd_byte(rb), .acc_start(a_st), .acc_ptr(ptr),
    .wr_strobe(w_st), .wr_byte(wb), .rd_req(r_rq), .convert_pin(cvp));
  mcs_regs uut (.mclk(mclk), .resetn(resetn), .acc_start(a_st),
    .acc_ptr(ptr), .wr_strobe(w_st), .wr_byte(wb), .rd_req(r_rq),
    .rd_byte(rb), .rd_valid(), .limit_exceeded(lim), .warn_latch_en(wl),
    .limit_latch_en(ll), .severe_latch_en(sl), .conv_done_pulse(cdp),
    .math_overflow_pulse(ovp), .convert_pin(cvp), .bus_range_select(brs),
    .shunt_gain_select(gain), .bus_conv_setting(bcv),
    .shunt_conv_setting(scv), .bus_res_bits(bres), .bus_avg_log2(),
    .shunt_res_bits(sres), .shunt_avg_log2(), .shunt_meas_en(mode[0]),
    .bus_meas_en(mode[1]), .continuous_mode(mode[2]),
    .convert_trigger(trig), .alert_n_out(), .alert_n_oe(oe),
    .warning_pin(wpin), .limit_pin(lpin), .severe_pin(spin));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) tseen <= 1'b1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  // ========================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] p, input logic [15:0] e, string nm);
    logic [15:0] d;
    h.rd(p, d);
    chk(nm, d, e);
  endtask : rchk
  task automatic pulse(input logic [11:0] v);
    @(negedge mclk) {ovp, cdp, lim} = v;
    @(negedge mclk) {ovp, cdp, lim} = 12'h000;
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ========================================
  // Tests
  initial begin
    {resetn, wl, ll, sl, tseen, ovp, cdp, lim} = 17'h00000;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    rchk(CF, 16'h399F, "cfg");
    chk("range", 16'(brs), 16'h0001);
    chk("gain", 16'(gain), 16'h0003);
    chk("mode", 16'(mode), 16'h0007);
    rchk(ST, 16'h0000, "st");
    rchk(MK, 16'h0000, "mask");
    $display("test reset done");
    h.wr(CF, 16'h0123);
    repeat (2) @(negedge mclk);
    chk("range", 16'(brs), 16'h0000);
    chk("gain", 16'(gain), 16'h0000);
    chk("bconv", 16'(bcv), 16'h0002);
    chk("sconv", 16'(scv), 16'h0004);
    chk("bres", 16'(bres), 16'h000B);
    chk("sres", 16'(sres), 16'h0009);
    chk("mode", 16'(mode), 16'h0003);
    h.wr(CF, 16'h7FFF);
    rchk(CF, 16'h3FFF, "cfg");
    h.wr(ST, 16'hFFFF);
    rchk(ST, 16'h0000, "st");
    rchk(8'h05, 16'h0000, "unmapped");
    $display("test config done");
    h.wr(MK, 16'h8009);
    wl = 1'b1;
    pulse(12'h200);
    repeat (4) @(negedge mclk);
    chk("alert", 16'(oe), 16'h0001);
    chk("wpin", 16'(wpin), 16'h0001);
    rchk(ST, 16'h8010, "st");
    rchk(ST, 16'h0000, "st");
    repeat (3) @(negedge mclk);
    chk("alert", 16'(oe), 16'h0000);
    pulse(12'h200);
    h.wr(MK, 16'h8001);
    rchk(ST, 16'h8000, "st");
    rchk(ST, 16'h0000, "st");
    $display("test alert done");
    lim[2] = 1'b1;
    repeat (2) @(negedge mclk);
    rchk(ST, 16'h0100, "st");
    rchk(ST, 16'h0100, "st");
    lim = 10'h000;
    repeat (2) @(negedge mclk);
    rchk(ST, 16'h0000, "st");
    h.wr(MK, 16'h0008);
    pulse(12'h800);
    repeat (3) @(negedge mclk);
    chk("alert", 16'(oe), 16'h0000);
    rchk(ST, 16'h0008, "st");
    $display("test flags done");
    pulse(12'h400);
    rchk(ST, 16'h0020, "st");
    pulse(12'h400);
    h.wr(CF, 16'h399F);
    rchk(ST, 16'h0000, "st");
    h.wr(CF, 16'h3998);
    pulse(12'h400);
    h.wr(CF, 16'h3998);
    rchk(ST, 16'h0020, "st");
    h.wr(CF, 16'h3993);
    pulse(12'h400);
    h.cv();
    repeat (6) @(negedge mclk);
    chk("trig", 16'(tseen), 16'h0001);
    rchk(ST, 16'h0000, "st");
    $display("test done flag done");
    h.wr(MK, 16'h0006);
    sl = 1'b1;
    lim = 10'h005;
    repeat (3) @(negedge mclk);
    chk("lpin", 16'(lpin), 16'h0001);
    chk("spin", 16'(spin), 16'h0001);
    lim = 10'h000;
    repeat (3) @(negedge mclk);
    chk("lpin", 16'(lpin), 16'h0000);
    chk("spin", 16'(spin), 16'h0001);
    rchk(ST, 16'h0040, "st");
    $display("test pins done");
    h.wr(MK, 16'h8009);
    h.wr(CF, 16'h8000);
    rchk(CF, 16'h399F, "cfg");
    rchk(MK, 16'h0000, "mask");
    $display("test soft reset done");
    print_verdict();
  end
endmodule : mcs_regs_tb
`default_nettype wire
